// File: logic/watchdog_timeout_pkg.sv
// Package for the watchdog timeout unit: addresses, field layout, counts.
// Assumes an 8-bit CPU bus with a 16-bit address, clocked by the internal oscillator clock.
package watchdog_timeout_pkg;

    localparam logic [15:0] CLEAR_ADDR      = 16'hFFFF;
    localparam int          PRESCALE_BITS   = 12;
    localparam int          COUNT_BITS      = 6;
    // Prescaler stages cleared by a service write
    localparam int          SERVICE_CLR_LO  = 5;
    localparam int          SERVICE_CLR_HI  = 12;
    // Prescaler tap that advances the counter: short rate 2^13, long rate 2^18
    localparam int          TAP_SHORT       = 7;
    localparam int          TAP_LONG        = 12;
    localparam logic [5:0]  SHORT_CNT_LIMIT = 6'h3F;
    localparam logic [5:0]  LONG_CNT_LIMIT  = 6'h3F;
    localparam logic [11:0] SHORT_PRE_END   = 12'h070;
    localparam logic [11:0] LONG_PRE_END    = 12'hFF0;
    localparam int          RESET_HOLD      = 32;
    localparam logic [5:0]  RESET_HOLD_LAST = 6'(RESET_HOLD - 1);

    localparam int          CFG_RATE_BIT    = 0;
    localparam int          CFG_DIS_BIT     = 1;
    localparam int          CFG_STOPEN_BIT  = 2;
    localparam logic [7:0]  CFG_RESET       = 8'h00;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } bus_req_type;

    typedef struct packed {
        logic monitor_irq_vtst;
        logic monitor_blank_vec;
        logic irq_pin_vtst;
        logic rst_pin_vtst;
        logic break_active;
        logic wait_mode;
        logic stop_req;
    } mode_in_type;

endpackage

// File: logic/watchdog_timeout_unit.sv
// Watchdog timeout unit: 12-bit prescaler feeding a 6-bit counter, reset request on overflow.
// Assumes the bus, the mode signals and the reset vector byte are synchronous to i_clk_sys.
module watchdog_timeout_unit
(
    input  wire logic                              i_clk_sys,
    input  wire logic                              i_resetn,
    input  wire logic                              i_por,
    input  wire logic                              i_internal_reset,
    input  wire watchdog_timeout_pkg::bus_req_type i_bus,
    input  wire logic                              i_cfg_wr,
    input  wire logic [7:0]                        i_cfg_wdata,
    input  wire logic [7:0]                        i_reset_vector_lo,
    input  wire watchdog_timeout_pkg::mode_in_type i_mode,
    output logic [7:0]                             o_rdata,
    output logic [7:0]                             o_cfg_rdata,
    output logic                                   o_reset_pin_n,
    output logic                                   o_watchdog_reset_flag,
    output logic                                   o_illegal_op_reset,
    output logic                                   o_irq
);

    logic [7:0]  cfg_r;
    logic [11:0] pre_r;
    logic [11:0] pre_nxt;
    logic [5:0]  cnt_r;
    logic [5:0]  cnt_nxt;
    logic        mon_vtst_r;
    logic        mon_blank_r;
    logic        hold_r;
    logic [5:0]  hold_cnt_r;
    logic [7:0]  rdata_r;
    logic        flag_r;
    logic        illegal_r;
    logic        pin_n_r;
    logic        irq_r;

    wire         rate_short  = cfg_r[watchdog_timeout_pkg::CFG_RATE_BIT];
    wire         cfg_disable = cfg_r[watchdog_timeout_pkg::CFG_DIS_BIT];
    wire         stop_allow  = cfg_r[watchdog_timeout_pkg::CFG_STOPEN_BIT];
    wire         hit_clear   = i_bus.addr == watchdog_timeout_pkg::CLEAR_ADDR;
    wire         service     = i_bus.wr && hit_clear;
    wire         stop_entry  = i_mode.stop_req && stop_allow;
    wire         stop_bad    = i_mode.stop_req && !stop_allow;
    wire         vtst_hold   = mon_vtst_r
                               && (i_mode.irq_pin_vtst || i_mode.rst_pin_vtst);
    wire         brk_off     = i_mode.break_active && i_mode.rst_pin_vtst;
    // Wait mode does not appear here, so counting continues while waiting
    wire         disabled    = cfg_disable || vtst_hold || mon_blank_r || brk_off;
    wire         clear_all   = i_internal_reset || hold_r;
    wire [11:0]  pre_inc     = pre_r + 12'h001;
    wire         tick        = rate_short
                               ? (pre_r[watchdog_timeout_pkg::TAP_SHORT-1:0] == 7'h7F)
                               : (pre_r == 12'hFFF);
    wire [5:0]   cnt_limit   = rate_short ? watchdog_timeout_pkg::SHORT_CNT_LIMIT
                                          : watchdog_timeout_pkg::LONG_CNT_LIMIT;
    wire [11:0]  pre_end     = rate_short ? watchdog_timeout_pkg::SHORT_PRE_END
                                          : watchdog_timeout_pkg::LONG_PRE_END;
    // Short rate looks only at the low seven prescaler stages; the upper stages free-run
    wire         pre_at_end  = rate_short
                               ? (pre_r[watchdog_timeout_pkg::TAP_SHORT-1:0]
                                  == pre_end[watchdog_timeout_pkg::TAP_SHORT-1:0])
                               : (pre_r == pre_end);
    // Last 2^4 prescaler cycles of the final count are cut off: overflow comes 2^4 early
    wire         overflow    = !disabled && !clear_all && !service
                               && cnt_r == cnt_limit && pre_at_end;
    wire [11:0]  pre_srv     = {pre_r[11:watchdog_timeout_pkg::SERVICE_CLR_LO-1] & 8'h00,
                                pre_r[watchdog_timeout_pkg::SERVICE_CLR_LO-2:0]};
    // Next state of the reset pulse; the pin register copies it so the pin is a flop
    wire         hold_last   = hold_cnt_r == watchdog_timeout_pkg::RESET_HOLD_LAST;
    wire         hold_nxt    = overflow || (hold_r && !hold_last);

    // Prescaler: a stop clears it but not the counter, so the time left is longer
    always_comb
    begin
        pre_nxt = pre_r;
        if (clear_all || stop_entry)
        begin
            pre_nxt = 12'h000;
        end
        else if (service)
        begin
            pre_nxt = pre_srv;
        end
        else if (!disabled)
        begin
            pre_nxt = pre_inc;
        end
    end

    // Counter: a stop alone leaves it where it is
    always_comb
    begin
        cnt_nxt = cnt_r;
        if (clear_all)
        begin
            cnt_nxt = 6'h00;
        end
        else if (stop_entry)
        begin
            cnt_nxt = cnt_r;
        end
        else if (service)
        begin
            cnt_nxt = 6'h00;
        end
        else if (!disabled && tick)
        begin
            cnt_nxt = cnt_r + 6'h01;
        end
    end

    // New rate and disable bits act from the edge after the write
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            cfg_r <= watchdog_timeout_pkg::CFG_RESET;
        end
        else if (i_cfg_wr)
        begin
            cfg_r <= i_cfg_wdata;
        end
    end

    // Prescaler and counter run on every edge; holds are expressed in their next values
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            pre_r <= 12'h000;
        end
        else
        begin
            pre_r <= pre_nxt;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            cnt_r <= 6'h00;
        end
        else
        begin
            cnt_r <= cnt_nxt;
        end
    end

    // Test-voltage monitor entry is sampled at power-on and ends once both pins drop
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            mon_vtst_r <= 1'b0;
        end
        else if (i_por)
        begin
            mon_vtst_r <= i_mode.monitor_irq_vtst;
        end
        else if (mon_vtst_r
                 && !(i_mode.irq_pin_vtst || i_mode.rst_pin_vtst))
        begin
            mon_vtst_r <= 1'b0;
        end
    end

    // Blank-vector monitor entry keeps the watchdog off until the next power-on
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            mon_blank_r <= 1'b0;
        end
        else if (i_por)
        begin
            mon_blank_r <= i_mode.monitor_blank_vec && !i_mode.monitor_irq_vtst;
        end
    end

    // Pulse length counter; it restarts on every overflow
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            hold_r     <= 1'b0;
            hold_cnt_r <= 6'h00;
        end
        else
        begin
            hold_r <= hold_nxt;
            if (overflow)
            begin
                hold_cnt_r <= 6'h00;
            end
            else if (hold_r)
            begin
                hold_cnt_r <= hold_cnt_r + 6'h01;
            end
        end
    end

    // Set wins over a power-on clear in the same cycle, so no timeout is lost
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            flag_r <= 1'b0;
        end
        else if (overflow)
        begin
            flag_r <= 1'b1;
        end
        else if (i_por && !hold_r)
        begin
            flag_r <= 1'b0;
        end
    end

    // Pin register follows the pulse state, so it falls the edge after overflow
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            pin_n_r <= 1'b1;
        end
        else
        begin
            pin_n_r <= !hold_nxt;
        end
    end

    // Read data stands one cycle; other addresses read as zero from this block
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            rdata_r <= 8'h00;
        end
        else
        begin
            rdata_r <= (i_bus.rd && hit_clear) ? i_reset_vector_lo : 8'h00;
        end
    end

    // The reset that follows is raised outside; this only flags the bad stop
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            illegal_r <= 1'b0;
        end
        else
        begin
            illegal_r <= stop_bad;
        end
    end

    // Kept as a register only so every output leaves from a flop
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            irq_r <= 1'b0;
        end
        else
        begin
            irq_r <= 1'b0;
        end
    end

    assign o_rdata               = rdata_r;
    assign o_cfg_rdata           = cfg_r;
    assign o_reset_pin_n         = pin_n_r;
    assign o_watchdog_reset_flag = flag_r;
    assign o_illegal_op_reset    = illegal_r;
    assign o_irq                 = irq_r;

endmodule

// File: test/cpu_bus_model.sv
// CPU-side model: holds the reset vector byte and issues one-cycle bus accesses.
// Assumes accesses are launched at the falling edge of the internal clock.
module cpu_bus_model
#(
    parameter logic [7:0] VEC_LO = 8'hA5
)
(
    input  wire logic                         i_clk_sys,
    output watchdog_timeout_pkg::bus_req_type o_bus,
    output logic [7:0]                        o_vec
);
    timeunit 1ns;
    timeprecision 1ps;
    assign o_vec = VEC_LO;
    initial o_bus = '0;
    // Strobe stands across one rising edge only, so it is never taken twice
    task access(input logic rd, input logic [15:0] addr, input logic [7:0] d);
        @(negedge i_clk_sys);
        o_bus = {rd, ~rd, addr, d};
        @(negedge i_clk_sys);
        o_bus = '0;
    endtask
endmodule

// File: test/watchdog_timeout_unit_assertions.sv
// Checker for the watchdog timeout unit, bound to its ports.
// Assumes one clock domain with an active-low asynchronous reset.
module watchdog_timeout_unit_checker
(
    input wire logic                              i_clk_sys,
    input wire logic                              i_resetn,
    input wire watchdog_timeout_pkg::bus_req_type i_bus,
    input wire logic [7:0]                        i_reset_vector_lo,
    input wire watchdog_timeout_pkg::mode_in_type i_mode,
    input wire logic [7:0]                        o_rdata,
    input wire logic [7:0]                        o_cfg_rdata,
    input wire logic                              o_reset_pin_n,
    input wire logic                              o_watchdog_reset_flag,
    input wire logic                              o_illegal_op_reset,
    input wire logic                              o_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    wire top_hit = i_bus.addr == watchdog_timeout_pkg::CLEAR_ADDR;
    wire pin     = o_reset_pin_n;
    a_no_irq: assert property (o_irq == 1'b0) else $error("irq raised");
    a_read_vector: assert property (i_bus.rd && top_hit |=>
        o_rdata == $past(i_reset_vector_lo)) else $error("bad read data");
    a_pin_hold: assert property ($fell(pin) |-> ##31 !pin ##1 pin)
        else $error("reset pulse length");
    a_illegal_stop: assert property (i_mode.stop_req &&
        !o_cfg_rdata[watchdog_timeout_pkg::CFG_STOPEN_BIT] |=> o_illegal_op_reset)
        else $error("no illegal reset");
    a_disabled_quiet: assert property (
        o_cfg_rdata[watchdog_timeout_pkg::CFG_DIS_BIT] && pin |=> pin)
        else $error("fired while disabled");
    a_monitor_off: assert property (i_mode.monitor_irq_vtst && pin &&
        (i_mode.irq_pin_vtst || i_mode.rst_pin_vtst) |=> pin) else $error("monitor fire");
    a_break_off: assert property (i_mode.break_active && i_mode.rst_pin_vtst && pin
        |=> pin) else $error("break fire");
    a_service_hold: assert property (i_bus.wr && top_hit && pin |=> pin[*8])
        else $error("fire after service");
    a_flag_on_pulse: assert property (!pin |-> o_watchdog_reset_flag)
        else $error("source flag missing");
endmodule

bind watchdog_timeout_unit watchdog_timeout_unit_checker chk (.*);

// File: test/watchdog_timeout_unit_tb.sv
// Self-checking bench for the watchdog timeout unit, short rate only.
// Assumes the bus model drives accesses; mode inputs driven here.
module watchdog_timeout_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] VEC = 8'hA5;
    logic       clk, resetn, por, int_rst, cfg_wr, pin_n, flag, ill, irq;
    logic [7:0] cfg_d, rdata, cfg_q, vec;
    watchdog_timeout_pkg::bus_req_type bus;
    watchdog_timeout_pkg::mode_in_type mode;
    int         err_count = 0, check_count = 0, cyc = 0, n;
    cpu_bus_model #(.VEC_LO(VEC)) model (.i_clk_sys(clk), .o_bus(bus), .o_vec(vec));
    watchdog_timeout_unit dut (.i_clk_sys(clk), .i_resetn(resetn), .i_por(por),
        .i_internal_reset(int_rst), .i_bus(bus), .i_cfg_wr(cfg_wr), .i_cfg_wdata(cfg_d),
        .i_reset_vector_lo(vec), .i_mode(mode), .o_rdata(rdata), .o_cfg_rdata(cfg_q),
        .o_reset_pin_n(pin_n), .o_watchdog_reset_flag(flag),
        .o_illegal_op_reset(ill), .o_irq(irq));
    initial
    begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    // Whole run is about 77k cycles
    always @(posedge clk)
        if (++cyc > 90000)
        begin
            err_count++;
            wrap_up;
        end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        $display("comparisons %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task set_cfg(input logic [7:0] d);
        @(negedge clk);
        cfg_wr = 1;
        cfg_d = d;
        @(negedge clk);
        cfg_wr = 0;
    endtask
    task clear_unit;
        @(negedge clk);
        int_rst = 1;
        @(negedge clk);
        int_rst = 0;
    endtask
    task t_read;
        model.access(1, 16'hFFFF, 8'h00);
        check(rdata, VEC);
        model.access(1, 16'hFFFE, 8'h00);
        check(rdata, 8'h00);
        $display("read test done");
    endtask
    task t_timeout;
        mode.wait_mode = 1;
        set_cfg(8'h05);
        clear_unit;
        for (n = 0; pin_n !== 0 && n < 9000; n++) @(negedge clk);
        check(n inside {[8174:8178]}, 1);
        for (n = 0; pin_n === 0 && n < 40; n++) @(negedge clk);
        check(n, 32);
        check(flag, 1);
        mode.wait_mode = 0;
        $display("timeout test done");
    endtask
    task t_service;
        repeat (8000) @(negedge clk);
        model.access(0, 16'hFFFF, 8'h5A);
        repeat (8000) @(negedge clk);
        check(pin_n, 1);
        repeat (400) @(negedge clk);
        $display("service test done");
    endtask
    task t_disable;
        set_cfg(8'h03);
        check(cfg_q, 8'h03);
        repeat (9000) @(negedge clk);
        check(pin_n, 1);
        @(negedge clk);
        mode.stop_req = 1;
        @(negedge clk);
        mode.stop_req = 0;
        check(ill, 1);
        check(irq, 0);
        $display("disable and stop test done");
    endtask
    task t_stop;
        set_cfg(8'h05);
        clear_unit;
        repeat (8000) @(negedge clk);
        mode.stop_req = 1;
        @(negedge clk);
        mode.stop_req = 0;
        check(ill, 0);
        repeat (199) @(negedge clk);
        check(pin_n, 1);
        for (n = 0; pin_n !== 0 && n < 100; n++) @(negedge clk);
        check(n inside {[40:44]}, 1);
        for (n = 0; pin_n === 0 && n < 40; n++) @(negedge clk);
        model.access(0, 16'hFFFF, 8'h00);
        mode.stop_req = 1;
        @(negedge clk);
        mode.stop_req = 0;
        repeat (8100) @(negedge clk);
        check(pin_n, 1);
        $display("stop test done");
    endtask
    task t_modes;
        set_cfg(8'h05);
        for (int k = 0; k < 3; k++)
        begin
            @(negedge clk);
            mode = (k == 2) ? 7'h20 : (k ? 7'h50 : 7'h0C);
            por = 1;
            @(negedge clk);
            por = 0;
            if (k == 2)
                mode = '0;
            repeat (9000) @(negedge clk);
            check(pin_n, 1);
        end
        $display("mode test done");
    endtask
    initial
    begin
        resetn = 0;
        por = 1;
        int_rst = 0;
        cfg_wr = 0;
        cfg_d = 8'h00;
        mode = '0;
        repeat (3) @(negedge clk);
        resetn = 1;
        por = 0;
        t_read;
        t_timeout;
        t_service;
        t_disable;
        t_stop;
        t_modes;
        wrap_up;
    end
endmodule
